/* rtl/cc_cfg.svh */
/*
 * constants of the converter control block: register indices, field positions,
 * reset values and conversion lengths.
 * assumes it is included by bare name from files under rtl/ and test/.
 */
`ifndef CC_CFG_SVH
`define CC_CFG_SVH

// register indices; the byte address on the bus is four times the index
`define CC_IDX_CTRL 10'h0a4
`define CC_IDX_TRIG 10'h0a6
`define CC_IDX_RESULT 10'h0a8

// control register fields
`define CC_BIT_DONE 7
`define CC_BIT_BUSY 6
`define CC_BIT_MODE 5
`define CC_BIT_EN 4
`define CC_BIT_RESULT_LEFT_ALIGN 3
`define CC_CKSEL_HI 2
`define CC_CKSEL_LO 0
`define CC_CTRL_RESET 8'h00

// trigger register fields
`define CC_TRG_HI 1
`define CC_TRG_LO 0
`define CC_TRG_RESET 2'h0
`define CC_TRG_SOFTWARE 2'h0

// conversion lengths in converter clock cycles
`define CC_ADC_CYCLES 4'hd
`define CC_DAC_CYCLES 4'hb
`define CC_SAMPLE_CYCLE 4'h3

// internal oscillator divider, oscillator clock select and sample and result widths
`define CC_RC_LAST 2'h3
`define CC_CKSEL_RC 3'h0
`define CC_SAMPLE_W 10
`define CC_RESULT_W 16

`endif

/* rtl/cc_clock_gen.sv */
/*
 * converter clock generator: a one-cycle tick per converter clock period.
 * assumes clk_sys_in is the oscillator source ahead of any cpu clock divider,
 * and rc_osc_in is a free-running internal oscillator from another domain.
 */
`include "cc_cfg.svh"
module cc_clock_gen
	import cc_pkg::*;
(
	input wire logic clk_sys_in,
	input wire logic rst_in,
	input wire logic rc_osc_in,
	cc_conv_if.clkgen cv
);
	logic rc_meta;
	logic rc_sync;
	logic rc_last;
	logic [1:0] rc_count;
	logic [6:0] pre_count;
	wire rc_rise = rc_sync & ~rc_last;
	// prescaler taps: /2^sel wraps when the low sel bits are all ones
	wire [7:0] tap_wide = (8'h01 << cv.clk_sel) - 8'h01;
	wire [6:0] tap_mask = tap_wide[6:0];
	wire pre_tick = (pre_count & tap_mask) == tap_mask;
	wire rc_tick = rc_rise && (rc_count == `CC_RC_LAST);

	// oscillator pin passes two flops before the edge detector sees it
	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			rc_meta <= 1'b0;
			rc_sync <= 1'b0;
			rc_last <= 1'b0;
		end else begin
			rc_meta <= rc_osc_in;
			rc_sync <= rc_meta;
			rc_last <= rc_sync;
		end
	end

	// counters are cleared and held at zero while disabled, so they do not toggle in idle; the oscillator synchroniser keeps running
	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			rc_count <= 2'h0;
			pre_count <= 7'h00;
		end else if (!cv.enable) begin
			rc_count <= 2'h0;
			pre_count <= 7'h00;
		end else begin
			if (rc_rise)
				rc_count <= rc_count + 2'h1;
			pre_count <= pre_count + 7'h01;
		end
	end

	assign cv.tick = cv.enable && ((cv.clk_sel == `CC_CKSEL_RC) ? rc_tick : pre_tick);
endmodule

/* rtl/cc_conv_if.sv */
/*
 * carrier between the control top, the clock generator and the sequencer.
 * assumes all three parties run on the system clock.
 */
interface cc_conv_if;
	import cc_pkg::*;
	logic enable;
	logic [2:0] clk_sel;
	logic tick;
	logic start;
	logic dac_mode;
	logic done_toggle;
	logic active;
	logic sample_strobe;
	cc_sample_t sample_word;
	modport ctl (output enable, output clk_sel, output start, output dac_mode,
		input tick, input done_toggle, input active, input sample_strobe, input sample_word);
	modport clkgen (input enable, input clk_sel, output tick);
	modport seq (input enable, input tick, input start, input dac_mode,
		output done_toggle, output active, output sample_strobe, output sample_word);
endinterface

/* rtl/cc_pkg.sv */
/*
 * types of the converter control block.
 * assumes cc_cfg.svh holds the numeric constants.
 */
package cc_pkg;
	typedef enum logic [0:0] {
		CC_IDLE,
		CC_RUN
	} cc_state_e;
	typedef logic [9:0] cc_sample_t;
endpackage

/* rtl/cc_sequencer.sv */
/*
 * conversion sequencer counting converter clock ticks.
 * assumes a one-cycle start pulse and a sample word that is valid at the last tick.
 */
`include "cc_cfg.svh"
module cc_sequencer
	import cc_pkg::*;
(
	input wire logic clk_sys_in,
	input wire logic rst_in,
	input wire cc_sample_t adc_sample_in,
	cc_conv_if.seq cv
);
	cc_state_e state;
	logic pending;
	logic mode;
	logic [3:0] count;
	logic toggle;
	cc_sample_t sample;
	wire [3:0] last = mode ? `CC_DAC_CYCLES : `CC_ADC_CYCLES;
	wire [3:0] next_count = count + 4'h1;
	wire finish = (state == CC_RUN) && cv.tick && (next_count == last);

	// a start waits for the next tick; clearing enable aborts at once
	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			state <= CC_IDLE;
			pending <= 1'b0;
			mode <= 1'b0;
			count <= 4'h0;
		end else if (!cv.enable) begin
			state <= CC_IDLE;
			pending <= 1'b0;
			count <= 4'h0;
		end else begin
			case (state)
				CC_IDLE: begin
					if (cv.start) begin
						pending <= 1'b1;
						mode <= cv.dac_mode;
					end
					if (pending && cv.tick) begin
						state <= CC_RUN;
						pending <= 1'b0;
						count <= 4'h1;
					end
				end
				CC_RUN: begin
					if (finish)
						state <= CC_IDLE;
					else if (cv.tick)
						count <= next_count;
				end
				default: state <= CC_IDLE;
			endcase
		end
	end

	// completion is a toggle so the top can resynchronise it as an event
	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			toggle <= 1'b0;
			sample <= '0;
		end else if (finish) begin
			toggle <= ~toggle;
			sample <= adc_sample_in;
		end
	end

	assign cv.done_toggle = toggle;
	assign cv.sample_word = sample;
	assign cv.active = (state == CC_RUN) || pending;
	assign cv.sample_strobe = (state == CC_RUN) && !mode && cv.tick && (next_count == `CC_SAMPLE_CYCLE);
endmodule

/* rtl/cc_top.sv */
/*
 * converter control and status: apb slave with the control, trigger and
 * result registers, start logic, completion flag and result alignment.
 * assumes an apb master on the system clock, timer overflow pulses and the
 * interrupt vector acknowledge on the same clock, and an analog core that
 * offers a signed ten-bit sample at the end of each conversion.
 */
// Our own choice: the APB register port.
`include "cc_cfg.svh"

// Contract
// - control register bit layout, flag at seven
// - done flag set at end, cleared by vector
// - software trigger: writing one starts conversion
// - busy stays set until conversion completes
// - timer triggers drive busy by hardware
// - mode bit selects dac when set
// - converter runs only while enabled
// - right aligned result is sign extended
// - left adjust bit left aligns result
// - select zero uses oscillator divided four
// - selects one to seven divide by powers
// - start needs the enable bit set
// - adc takes thirteen clocks, writes result
// - dac takes eleven clocks, sets flag
// - every selected timer overflow starts conversion (code drops one that arrives while busy)
module cc_top
	import cc_pkg::*;
(
	input wire logic clk_sys_in,
	input wire logic rst_in,
	input wire logic psel_in,
	input wire logic penable_in,
	input wire logic pwrite_in,
	input wire logic [11:0] paddr_in,
	input wire logic [31:0] pwdata_in,
	input wire logic [3:0] pstrb_in,
	output logic [31:0] prdata_out,
	output logic pready_out,
	output logic pslverr_out,
	input wire logic isr_vector_ack_in,
	input wire logic [2:0] timer_overflow_in,
	input wire logic rc_osc_in,
	input wire cc_sample_t adc_sample_in,
	output logic conv_enable_out,
	output logic dac_mode_out,
	output logic conv_tick_out,
	output logic conv_active_out,
	output logic sample_strobe_out,
	output logic dac_load_out,
	output logic [15:0] result_out,
	output logic conversion_done_flag_out,
	output logic start_busy_flag_out
);
	cc_conv_if cv ();

	// software visible state
	logic conversion_done_flag;
	logic start_busy_flag;
	logic dac_mode;
	logic converter_enable;
	logic result_left_align;
	logic [2:0] clock_select;
	logic [1:0] trigger_select;
	logic [15:0] result;
	logic [31:0] prdata;
	logic dac_load;

	// completion crossing: toggle, two flops, then an edge detector
	logic done_meta;
	logic done_sync;
	logic done_seen;

	// -------------------------------------------------------------
	// bus decode
	// -------------------------------------------------------------

	// word index; the two low address bits must be zero
	wire [9:0] word_index = paddr_in[11:2];
	wire aligned = (paddr_in[1:0] == 2'h0);
	wire hit_ctrl = aligned && (word_index == `CC_IDX_CTRL);
	wire hit_trig = aligned && (word_index == `CC_IDX_TRIG);
	wire hit_result = aligned && (word_index == `CC_IDX_RESULT);
	wire hit_any = hit_ctrl || hit_trig || hit_result;

	// setup phase loads the read data, access phase completes the transfer
	wire setup_phase = psel_in && !penable_in;
	wire access_phase = psel_in && penable_in;

	// writes land only on byte lane zero, the writable registers are a byte wide
	wire lane0 = pstrb_in[0];
	wire wr_access = access_phase && pwrite_in && lane0;
	wire wr_ctrl = wr_access && hit_ctrl;
	wire wr_trig = wr_access && hit_trig;

	// write data split into control fields
	wire [7:0] wbyte = pwdata_in[7:0];
	wire w_go = wbyte[`CC_BIT_BUSY];
	wire w_mode = wbyte[`CC_BIT_MODE];
	wire w_enable = wbyte[`CC_BIT_EN];
	wire w_result_left_align = wbyte[`CC_BIT_RESULT_LEFT_ALIGN];
	wire [2:0] w_cksel = wbyte[`CC_CKSEL_HI:`CC_CKSEL_LO];
	wire [1:0] w_trig = wbyte[`CC_TRG_HI:`CC_TRG_LO];

	// -------------------------------------------------------------
	// control register image
	// -------------------------------------------------------------

	// bit order from the top: done, busy, mode, enable, align, clock select
	wire [7:0] ctrl_image = {conversion_done_flag, start_busy_flag, dac_mode,
		converter_enable, result_left_align, clock_select};
	wire [7:0] trig_image = {6'h00, trigger_select};

	// read mux; unmapped words read as zero
	wire [31:0] read_mux = hit_ctrl ? {24'h000000, ctrl_image} :
		hit_trig ? {24'h000000, trig_image} :
		hit_result ? {16'h0000, result} : 32'h00000000;

	// -------------------------------------------------------------
	// start and busy
	// -------------------------------------------------------------

	// the enable that applies to a start is the one in force after this cycle,
	// so a single write may enable the converter and start it together
	wire next_enable = wr_ctrl ? w_enable : converter_enable;
	wire next_dac_mode = wr_ctrl ? w_mode : dac_mode;
	wire software_trigger = (trigger_select == `CC_TRG_SOFTWARE);

	// software start: a one written to the busy bit
	wire sw_start = wr_ctrl && w_go && software_trigger && next_enable;

	// timer start: the overflow of the timer picked by the trigger field
	wire [1:0] timer_pick = trigger_select - 2'h1;
	wire timer_fire = !software_trigger && timer_overflow_in[timer_pick];
	// an overflow while busy is dropped: the timer must run slower than a conversion
	wire hw_start = timer_fire && next_enable && !start_busy_flag;

	// sw_start while already busy restarts nothing; the running conversion goes on
	wire start = (sw_start && !start_busy_flag) || hw_start;

	// completion event seen in the register domain
	wire done_event = done_sync ^ done_seen;

	// -------------------------------------------------------------
	// bus answer
	// -------------------------------------------------------------

	// zero wait states; a miss or misaligned address answers with an error
	assign pready_out = 1'b1;
	assign pslverr_out = access_phase && !hit_any;
	assign prdata_out = prdata;

	// read data is captured in the setup cycle so it comes from a flop
	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in)
			prdata <= 32'h00000000;
		else if (setup_phase && !pwrite_in)
			prdata <= read_mux;
	end

	// -------------------------------------------------------------
	// configuration fields
	// -------------------------------------------------------------

	// mode, enable, alignment and clock select follow software writes
	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			dac_mode <= 1'b0;
			converter_enable <= 1'b0;
			result_left_align <= 1'b0;
			clock_select <= 3'h0;
		end else if (wr_ctrl) begin
			dac_mode <= w_mode;
			converter_enable <= w_enable;
			result_left_align <= w_result_left_align;
			clock_select <= w_cksel;
		end
	end

	// trigger source selection
	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in)
			trigger_select <= `CC_TRG_RESET;
		else if (wr_trig)
			trigger_select <= w_trig;
	end

	// -------------------------------------------------------------
	// status flags
	// -------------------------------------------------------------

	// busy: set by either start, cleared by the synced completion or disable;
	// a start is masked while busy is still set, so a request in the completion cycle is dropped
	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in)
			start_busy_flag <= 1'b0;
		else if (!next_enable)
			start_busy_flag <= 1'b0;
		else if (start)
			start_busy_flag <= 1'b1;
		else if (done_event)
			start_busy_flag <= 1'b0;
	end

	// done flag: hardware set beats the vector acknowledge in the same cycle
	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in)
			conversion_done_flag <= 1'b0;
		else if (done_event)
			conversion_done_flag <= 1'b1;
		else if (isr_vector_ack_in)
			conversion_done_flag <= 1'b0;
	end

	// completion crossing; only done_sync reads done_meta
	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			done_meta <= 1'b0;
			done_sync <= 1'b0;
			done_seen <= 1'b0;
		end else begin
			done_meta <= cv.done_toggle;
			done_sync <= done_meta;
			done_seen <= done_sync;
		end
	end

	// -------------------------------------------------------------
	// result alignment
	// -------------------------------------------------------------

	// the alignment in force when the completion is seen decides the layout
	wire [15:0] right_word = {{6{cv.sample_word[9]}}, cv.sample_word};
	wire [15:0] left_word = {cv.sample_word, 6'h00};
	wire [15:0] aligned_word = result_left_align ? left_word : right_word;

	// dac conversions leave the last adc result untouched
	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in)
			result <= 16'h0000;
		else if (done_event && !dac_mode)
			result <= aligned_word;
	end

	// dac buffer load: one system cycle at the start of a dac conversion
	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in)
			dac_load <= 1'b0;
		else
			dac_load <= start && next_dac_mode;
	end

	// -------------------------------------------------------------
	// sequencer and clock
	// -------------------------------------------------------------

	// the enable in force after this cycle, so a start in the enabling write is not lost
	assign cv.enable = next_enable;
	assign cv.clk_sel = clock_select;
	assign cv.start = start;
	assign cv.dac_mode = next_dac_mode;

	cc_clock_gen u_clock_gen (
		.clk_sys_in(clk_sys_in),
		.rst_in(rst_in),
		.rc_osc_in(rc_osc_in),
		.cv(cv.clkgen)
	);

	cc_sequencer u_sequencer (
		.clk_sys_in(clk_sys_in),
		.rst_in(rst_in),
		.adc_sample_in(adc_sample_in),
		.cv(cv.seq)
	);

	// -------------------------------------------------------------
	// outputs to the analog core and the cpu
	// -------------------------------------------------------------

	// the analog core is powered only while enabled
	assign conv_enable_out = converter_enable;
	assign dac_mode_out = dac_mode;
	assign conv_tick_out = cv.tick;
	assign conv_active_out = cv.active;
	assign sample_strobe_out = cv.sample_strobe;
	assign dac_load_out = dac_load;
	assign result_out = result;
	assign conversion_done_flag_out = conversion_done_flag;
	assign start_busy_flag_out = start_busy_flag;
endmodule

/* test/cc_analog_model.sv */
/*
 * model of the analog core, internal oscillator and timer overflow sources.
 * assumes the bench sets level and calls overflow; pulses follow the system clock.
 */
module cc_analog_model
	import cc_pkg::*;
(
	input wire logic clk_sys_in,
	input wire logic conv_active_in,
	output logic rc_osc_out,
	output cc_sample_t adc_sample_out,
	output logic [2:0] timer_overflow_out
);
	timeunit 1ns;
	timeprecision 100ps;
	cc_sample_t level = 10'h000;

	// free-running oscillator, phase unrelated to the system clock
	initial begin
		rc_osc_out = 1'b0;
		timer_overflow_out = 3'h0;
		#17;
		forever #62.5 rc_osc_out = ~rc_osc_out;
	end
	// sample valid only while converting; otherwise inverted so a late capture shows
	assign adc_sample_out = conv_active_in ? level : ~level;
	// one-cycle overflow pulse of one timer
	task automatic overflow(input int idx);
		@(posedge clk_sys_in);
		timer_overflow_out <= 3'h1 << idx;
		@(posedge clk_sys_in);
		timer_overflow_out <= 3'h0;
	endtask
endmodule

/* test/cc_top_chk.sv */
/*
 * checker for the converter control top: start, busy, completion and result timing.
 * assumes it is bound to cc_top and sees only the ports of that module.
 */
module cc_top_chk (
	input wire logic clk_sys_in,
	input wire logic rst_in,
	input wire logic isr_vector_ack_in,
	input wire logic conv_enable_out,
	input wire logic dac_mode_out,
	input wire logic conv_tick_out,
	input wire logic conv_active_out,
	input wire logic sample_strobe_out,
	input wire logic dac_load_out,
	input wire logic [15:0] result_out,
	input wire logic conversion_done_flag_out,
	input wire logic start_busy_flag_out
);
	default clocking cb @(posedge clk_sys_in);
	endclocking
	default disable iff (rst_in);

	// enable gates every converter activity
	a_tick_enabled: assert property (conv_tick_out |-> conv_enable_out)
		else $error("converter tick while disabled");
	a_abort_stops: assert property ($fell(conv_enable_out) |=> !start_busy_flag_out && !conv_active_out)
		else $error("conversion survives disable");
	a_start_enabled: assert property ($rose(start_busy_flag_out) |-> conv_enable_out)
		else $error("busy set while disabled");
	// busy ends only by completion while still enabled
	a_busy_to_done: assert property ($fell(start_busy_flag_out) && conv_enable_out |-> conversion_done_flag_out)
		else $error("busy cleared without completion");
	a_done_cause: assert property ($rose(conversion_done_flag_out) |-> $past(start_busy_flag_out))
		else $error("done set without a running conversion");
	// done is set three edges after the last tick, so its rise is seen four samples later
	a_done_sync: assert property ($rose(conversion_done_flag_out) |-> $past(conv_tick_out, 4))
		else $error("done not aligned to last tick");
	a_done_holds: assert property (conversion_done_flag_out && !isr_vector_ack_in |=> conversion_done_flag_out)
		else $error("done lost without vector");
	a_done_clear: assert property ($fell(conversion_done_flag_out) |-> $past(isr_vector_ack_in))
		else $error("done cleared without vector");
	a_strobe_adc: assert property (sample_strobe_out |-> conv_active_out && !dac_mode_out)
		else $error("sample strobe outside adc conversion");
	a_load_dac: assert property (dac_load_out |-> dac_mode_out && conv_active_out)
		else $error("dac load outside dac conversion");
	// result moves only together with an adc completion
	a_result_done: assert property ($changed(result_out) |-> conversion_done_flag_out && !dac_mode_out)
		else $error("result changed without adc completion");

	c_adc_done: cover property ($rose(conversion_done_flag_out) && !dac_mode_out);
	c_dac_done: cover property ($rose(conversion_done_flag_out) && dac_mode_out);
	c_abort: cover property ($fell(conv_enable_out) && $past(start_busy_flag_out));
endmodule

bind cc_top cc_top_chk i_cc_top_chk (.clk_sys_in(clk_sys_in), .rst_in(rst_in),
	.isr_vector_ack_in(isr_vector_ack_in), .conv_enable_out(conv_enable_out), .dac_mode_out(dac_mode_out),
	.conv_tick_out(conv_tick_out), .conv_active_out(conv_active_out), .sample_strobe_out(sample_strobe_out),
	.dac_load_out(dac_load_out), .result_out(result_out), .conversion_done_flag_out(conversion_done_flag_out),
	.start_busy_flag_out(start_busy_flag_out));

/* test/tb_cc_top.sv */
/*
 * self-checking bench of the converter control top over apb.
 * assumes zero-wait apb slave and the analog model as far side.
 */
`include "cc_cfg.svh"
module tb_cc_top;
	timeunit 1ns;
	timeprecision 100ps;
	logic clk_sys_in, rst_in, psel_in, penable_in, pwrite_in, isr_vector_ack_in, err;
	logic pready_out, pslverr_out, rc_osc, conv_enable_out, dac_mode_out, conv_tick_out, conv_active_out;
	logic sample_strobe_out, dac_load_out, conversion_done_flag_out, start_busy_flag_out;
	logic [11:0] paddr_in;
	logic [31:0] pwdata_in, prdata_out, rd;
	logic [2:0] timer_overflow;
	logic [15:0] result_out;
	cc_pkg::cc_sample_t adc_sample;
	int fails = 0, total_checks = 0, cycles = 0, nt = 0, loads = 0, g;
	localparam logic [11:0] addr_ctrl = {`CC_IDX_CTRL, 2'b00};
	localparam logic [11:0] addr_trig = {`CC_IDX_TRIG, 2'b00};
	localparam logic [11:0] addr_res = {`CC_IDX_RESULT, 2'b00};

	cc_top i_cc_top (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .psel_in(psel_in), .penable_in(penable_in),
		.pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in), .pstrb_in(4'hf),
		.prdata_out(prdata_out), .pready_out(pready_out), .pslverr_out(pslverr_out),
		.isr_vector_ack_in(isr_vector_ack_in), .timer_overflow_in(timer_overflow), .rc_osc_in(rc_osc),
		.adc_sample_in(adc_sample), .conv_enable_out(conv_enable_out), .dac_mode_out(dac_mode_out),
		.conv_tick_out(conv_tick_out), .conv_active_out(conv_active_out), .sample_strobe_out(sample_strobe_out),
		.dac_load_out(dac_load_out), .result_out(result_out), .conversion_done_flag_out(conversion_done_flag_out),
		.start_busy_flag_out(start_busy_flag_out));
	cc_analog_model i_cc_analog_model (.clk_sys_in(clk_sys_in), .conv_active_in(conv_active_out),
		.rc_osc_out(rc_osc), .adc_sample_out(adc_sample), .timer_overflow_out(timer_overflow));

	initial begin
		clk_sys_in = 1'b0;
		forever #25 clk_sys_in = ~clk_sys_in;
	end
	// cycle count, ticks of busy conversions, dac loads, and the hang limit
	always @(posedge clk_sys_in) begin
		cycles <= cycles + 1;
		if (start_busy_flag_out === 1'b1 && conv_tick_out === 1'b1) nt <= nt + 1;
		if (dac_load_out === 1'b1) loads <= loads + 1;
		if (cycles == 20000) begin
			fails = fails + 1;
			give_verdict();
		end
	end

	task automatic give_verdict();
		$display("checks %0d mismatches %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			fails++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// one apb transfer; request held until pready is seen high
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge clk_sys_in);
		psel_in <= 1'b1;
		pwrite_in <= w;
		paddr_in <= a;
		pwdata_in <= d;
		@(posedge clk_sys_in);
		penable_in <= 1'b1;
		do @(posedge clk_sys_in); while (pready_out !== 1'b1);
		rd = prdata_out;
		err = pslverr_out;
		psel_in <= 1'b0;
		penable_in <= 1'b0;
	endtask
	task automatic wait_tick();
		do @(posedge clk_sys_in); while (conv_tick_out !== 1'b1);
	endtask
	// steady distance between converter ticks
	task automatic gap(output int d);
		int t0;
		wait_tick();
		wait_tick();
		t0 = cycles;
		wait_tick();
		d = cycles - t0;
	endtask
	// start by software (src 0) or timer src-1, then run to completion and take the vector
	task automatic conv(input int src, input logic [31:0] ctrl, input int ticks);
		int n0;
		n0 = nt;
		if (src == 0) apb(1'b1, addr_ctrl, ctrl);
		else i_cc_analog_model.overflow(src - 1);
		apb(1'b0, addr_ctrl, 32'h0);
		chk(rd[7:6], 32'h1);
		while (conversion_done_flag_out !== 1'b1) @(posedge clk_sys_in);
		chk(nt - n0, ticks);
		chk(start_busy_flag_out, 32'h0);
		@(posedge clk_sys_in);
		isr_vector_ack_in <= 1'b1;
		@(posedge clk_sys_in);
		isr_vector_ack_in <= 1'b0;
		@(posedge clk_sys_in);
		chk(conversion_done_flag_out, 32'h0);
	endtask

	initial begin
		{rst_in, psel_in, penable_in, pwrite_in, isr_vector_ack_in} = 5'h10;
		paddr_in = 12'h000;
		pwdata_in = 32'h0;
		repeat (8) @(posedge clk_sys_in);
		rst_in <= 1'b0;
		// reset values and bit layout; done is read-only
		apb(1'b0, addr_ctrl, 32'h0);
		chk(rd, `CC_CTRL_RESET);
		apb(1'b1, addr_ctrl, 32'hbb);
		apb(1'b0, addr_ctrl, 32'h0);
		chk(rd, 32'h3b);
		chk({conv_enable_out, dac_mode_out}, 32'h3);
		apb(1'b1, addr_ctrl, 32'h20);
		@(posedge clk_sys_in);
		chk({conv_enable_out, dac_mode_out}, 32'h1);
		// unmapped address is refused
		apb(1'b1, 12'h004, 32'hff);
		chk(err, 32'h1);
		apb(1'b0, 12'h004, 32'h0);
		chk(err, 32'h1);
		chk(rd, 32'h0);
		// every clock select
		for (int s = 0; s < 8; s++) begin
			apb(1'b1, addr_ctrl, 32'h10 | s);
			gap(g);
			if (s == 0) chk(g >= 9 && g <= 11, 32'h1);
			else chk(g, 1 << s);
		end
		// start refused while disabled
		apb(1'b1, addr_ctrl, 32'h43);
		repeat (4) @(posedge clk_sys_in);
		chk(start_busy_flag_out, 32'h0);
		// adc right and left aligned, then dac leaves the result alone
		i_cc_analog_model.level = 10'h2a5;
		conv(0, 32'h53, 13);
		apb(1'b0, addr_res, 32'h0);
		chk(rd, 32'hfea5);
		i_cc_analog_model.level = 10'h155;
		conv(0, 32'h5b, 13);
		chk(result_out, 32'h5540);
		conv(0, 32'h73, 11);
		chk(loads, 32'h1);
		chk(result_out, 32'h5540);
		// abort by clearing enable: no completion
		apb(1'b1, addr_ctrl, 32'h53);
		apb(1'b1, addr_ctrl, 32'h03);
		repeat (150) @(posedge clk_sys_in);
		chk({start_busy_flag_out, conversion_done_flag_out}, 32'h0);
		// each timer trigger; other timers ignored
		for (int t = 1; t < 4; t++) begin
			apb(1'b1, addr_trig, t);
			apb(1'b1, addr_ctrl, 32'h13);
			i_cc_analog_model.overflow(t % 3);
			repeat (3) @(posedge clk_sys_in);
			chk(start_busy_flag_out, 32'h0);
			conv(t, 32'h0, 13);
			chk(result_out, 32'h0155);
		end
		// second reset in mid conversion
		apb(1'b1, addr_trig, 32'h0);
		apb(1'b1, addr_ctrl, 32'h53);
		rst_in <= 1'b1;
		repeat (2) @(posedge clk_sys_in);
		rst_in <= 1'b0;
		apb(1'b0, addr_ctrl, 32'h0);
		chk(rd, `CC_CTRL_RESET);
		give_verdict();
	end
endmodule
